//--- rtl/pmd_pkg.sv
// Package for the manufacturer command decoder: command codes, transaction
// kinds, reset values and fixed encodings.
// Assumes one system clock; the link layer hands over whole transactions.
package pmd_pkg;

  // ****************************************
  // Command codes
  // ****************************************
  localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;
  localparam logic [7:0] CMD_VOUT_MODE = 8'h20;
  localparam logic [7:0] CMD_MARGIN_HIGH = 8'h25;
  localparam logic [7:0] CMD_MARGIN_LOW = 8'h26;
  localparam logic [7:0] CMD_STATUS_WORD = 8'h79;
  localparam logic [7:0] CMD_READ_VOUT = 8'h8B;
  localparam logic [7:0] CMD_TEMP_OTHER = 8'h8E;
  localparam logic [7:0] CMD_POWER_OUT = 8'h96;
  localparam logic [7:0] CMD_POWER_IN = 8'h97;
  localparam logic [7:0] CMD_PROTO_REV = 8'h98;
  localparam logic [7:0] CMD_MODEL = 8'h9A;
  localparam logic [7:0] CMD_SI_REV = 8'h9B;
  localparam logic [7:0] CMD_PCALL_WRITE = 8'hD0;
  localparam logic [7:0] CMD_PCALL_READ = 8'hD1;
  localparam logic [7:0] CMD_OVERCLOCK = 8'hD2;
  localparam logic [7:0] CMD_SET_INDEX = 8'hD3;
  localparam logic [7:0] CMD_FETCH_BYTE = 8'hD4;
  localparam logic [7:0] CMD_DIRECT_WRITE = 8'hD5;
  localparam logic [7:0] CMD_SEC_ADDR = 8'hD6;
  localparam logic [7:0] CMD_EFFICIENCY = 8'hD7;
  localparam logic [7:0] CMD_MASK_WORD = 8'hD8;
  localparam logic [7:0] CMD_MASK_TEMP = 8'hD9;
  localparam logic [7:0] CMD_MASK_COMM = 8'hDA;
  localparam logic [7:0] CMD_MASK_MFR = 8'hDB;

  // ****************************************
  // Transaction kinds on cmd_kind_in
  // ****************************************
  localparam logic [2:0] KIND_SEND = 3'h0;
  localparam logic [2:0] KIND_WBYTE = 3'h1;
  localparam logic [2:0] KIND_WWORD = 3'h2;
  localparam logic [2:0] KIND_RBYTE = 3'h3;
  localparam logic [2:0] KIND_RWORD = 3'h4;
  localparam logic [2:0] KIND_BLOCK = 3'h5;
  localparam logic [2:0] KIND_PCALL = 3'h6;

  // ****************************************
  // Reset values and fixed encodings
  // ****************************************
  localparam logic [7:0] VOUT_MODE_RST = 8'h17;
  localparam logic [4:0] VOUT_EXP_MAX = 5'h01;
  localparam logic [4:0] VOUT_EXP_MIN = 5'h10;
  localparam logic [7:0] PROTO_REV_CODE = 8'h12;
  localparam logic [7:0] SEC_ADDR_RST = 8'h00;
  localparam logic [15:0] OVERCLOCK_RST = 16'h0000;
  localparam logic [15:0] MASK_WORD_RST = 16'h0000;
  localparam logic [7:0] MASK_BYTE_RST = 8'h00;
  localparam logic [15:0] MARGIN_RST = 16'h0000;
  localparam logic [7:0] INDEX_RST = 8'h00;
  localparam logic [1:0] CNT_NONE = 2'h0;
  localparam logic [1:0] CNT_BYTE = 2'h1;
  localparam logic [1:0] CNT_WORD = 2'h2;
  localparam int ZERO_FLAG_BIT = 11;

  // ****************************************
  // Telemetry exponents of the linear format
  // ****************************************
  localparam logic [4:0] TEMP_EXP = 5'h00;
  localparam logic [4:0] POWER_EXP = 5'h00;
  localparam logic [4:0] EFF_EXP = 5'h00;

  typedef enum logic {PMD_IDLE, PMD_REG_RD} pmd_state_t;

endpackage : pmd_pkg

//--- rtl/pmd_decoder.sv
// Decoder for the upper manufacturer command set of the regulator's
// management port, with telemetry packing and status masking.
// Assumes a link layer on mclk_in that delivers one decoded transaction at a
// time and an internal register file that answers reads one cycle later.

// Behaviour
// - 8Eh word returns other loop temperature
// - 96h word returns output power
// - 97h word returns input power
// - 98h byte reports revisions 1.1 and 1.2
// - 9Ah/9Bh block reads, two bytes, model/revision
// - D0h process call writes internal register
// - D1h process call reads internal register
// - D2h word sets overclocking profile options
// - D3h byte stores the read index
// - D4h byte reads register at stored index
// - D5h word: index low, value high
// - D6h bits 6..0 set secondary address
// - D6h bit 7 enables secondary bus
// - D7h word returns efficiency percent, linear
// - D8h word masks status word bits
// - D9h/DAh/DBh mask temperature, comm, manufacturer status
// - Output zero flag sticks until clear faults
// - Telemetry packed as exponent and signed mantissa
// - Sixteen-bit format only for output voltage commands
// - Voltage exponent from mode, mantissa unsigned
// - 03h send byte clears latched faults
// - Mode default exponent -9, range 1..-16
module pmd_decoder
  import pmd_pkg::*;
#(
  parameter logic [7:0] MODEL_LOW = 8'h3C, // Arbitrary value
  parameter logic [7:0] MODEL_ID = 8'h5A,  // Arbitrary value
  parameter logic [7:0] SI_REV = 8'h02     // Arbitrary value
) (
  // Clock, reset, enable
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  // Transaction request
  input wire logic cmd_valid_in,
  input wire logic [7:0] cmd_code_in,
  input wire logic [2:0] cmd_kind_in,
  input wire logic [15:0] cmd_data_in,
  output logic cmd_ready_out,
  // Transaction answer
  output logic rsp_valid_out,
  output logic [15:0] rsp_data_out,
  output logic [1:0] rsp_count_out,
  output logic rsp_error_out,
  // Internal register file
  output logic reg_wr_out,
  output logic reg_rd_out,
  output logic [7:0] reg_addr_out,
  output logic [7:0] reg_wdata_out,
  input wire logic [7:0] reg_rdata_in,
  // Telemetry
  input wire logic [10:0] thermistor_other_in,
  input wire logic [10:0] pout_mant_in,
  input wire logic [10:0] pin_mant_in,
  input wire logic [10:0] eff_mant_in,
  input wire logic [15:0] vout_mant_in,
  input wire logic vout_zero_in,
  // Status and masks
  input wire logic [15:0] status_word_in,
  output logic [15:0] status_word_out,
  output logic [7:0] mask_temp_out,
  output logic [7:0] comm_status_suppress_out,
  output logic [7:0] mask_mfr_out,
  output logic clear_faults_out,
  // Configuration
  output logic [15:0] overclock_out,
  output logic [6:0] sec_addr_out,
  output logic sec_en_out,
  output logic [4:0] vout_exp_out,
  output logic [15:0] margin_high_out,
  output logic [15:0] margin_low_out
);

  // ****************************************
  // State
  // ****************************************
  pmd_state_t state_r, state_nxt;
  logic [7:0] index_r, index_nxt;
  logic [15:0] oc_r, oc_nxt;
  logic [7:0] sec_r, sec_nxt;
  logic [7:0] vmode_r, vmode_nxt;
  logic [15:0] mhi_r, mhi_nxt, mlo_r, mlo_nxt;
  logic [15:0] mword_r, mword_nxt;
  logic [7:0] mtemp_r, mtemp_nxt, mcomm_r, mcomm_nxt, mmfr_r, mmfr_nxt;
  logic zero_r, zero_nxt, zprev_r, zprev_nxt;
  logic rv_r, rv_nxt, rerr_r, rerr_nxt, clr_r, clr_nxt;
  logic [15:0] rdat_r, rdat_nxt;
  logic [1:0] rcnt_r, rcnt_nxt;
  logic rwr_r, rwr_nxt, rrd_r, rrd_nxt;
  logic [7:0] raddr_r, raddr_nxt, rwd_r, rwd_nxt;
  logic [15:0] stat_r, stat_nxt;
  logic taken, wb, ww, rb, rw;
  logic [4:0] mode_exp;

  assign taken = cmd_valid_in && state_r == PMD_IDLE;
  assign wb = cmd_kind_in == KIND_WBYTE;
  assign ww = cmd_kind_in == KIND_WWORD;
  assign rb = cmd_kind_in == KIND_RBYTE;
  assign rw = cmd_kind_in == KIND_RWORD;
  assign mode_exp = cmd_data_in[4:0];

  // Decode of one transaction and next values of all state
  always_comb begin
    state_nxt = state_r;
    index_nxt = index_r;
    oc_nxt = oc_r;
    sec_nxt = sec_r;
    vmode_nxt = vmode_r;
    mhi_nxt = mhi_r;
    mlo_nxt = mlo_r;
    mword_nxt = mword_r;
    mtemp_nxt = mtemp_r;
    mcomm_nxt = mcomm_r;
    mmfr_nxt = mmfr_r;
    zprev_nxt = vout_zero_in;
    zero_nxt = zero_r;
    rv_nxt = 1'b0;
    rerr_nxt = 1'b0;
    clr_nxt = 1'b0;
    rdat_nxt = rdat_r;
    rcnt_nxt = rcnt_r;
    rwr_nxt = 1'b0;
    rrd_nxt = 1'b0;
    raddr_nxt = raddr_r;
    rwd_nxt = rwd_r;
    stat_nxt = status_word_in & ~mword_r;
    stat_nxt[ZERO_FLAG_BIT] = zero_r & ~mword_r[ZERO_FLAG_BIT];
    if (state_r == PMD_REG_RD) begin
      // Register file answers one cycle after the read strobe
      rv_nxt = 1'b1;
      rdat_nxt = {8'h00, reg_rdata_in};
      state_nxt = PMD_IDLE;
    end else if (taken) begin
      rv_nxt = 1'b1;
      rdat_nxt = 16'h0000;
      rcnt_nxt = CNT_NONE;
      if (cmd_code_in == CMD_CLEAR_FAULTS && cmd_kind_in == KIND_SEND) begin
        clr_nxt = 1'b1;
        zero_nxt = 1'b0;
      end else if (cmd_code_in == CMD_VOUT_MODE && wb) begin
        // Only linear mode with exponent 1 down to -16 is taken
        if (cmd_data_in[7:5] == 3'h0 && (mode_exp <= VOUT_EXP_MAX || mode_exp >= VOUT_EXP_MIN)) begin
          vmode_nxt = cmd_data_in[7:0];
        end else begin
          rerr_nxt = 1'b1;
        end
      end else if (cmd_code_in == CMD_VOUT_MODE && rb) begin
        rdat_nxt = {8'h00, vmode_r};
        rcnt_nxt = CNT_BYTE;
      end else if (cmd_code_in == CMD_MARGIN_HIGH && ww) begin
        mhi_nxt = cmd_data_in;
      end else if (cmd_code_in == CMD_MARGIN_HIGH && rw) begin
        rdat_nxt = mhi_r;
        rcnt_nxt = CNT_WORD;
      end else if (cmd_code_in == CMD_MARGIN_LOW && ww) begin
        mlo_nxt = cmd_data_in;
      end else if (cmd_code_in == CMD_MARGIN_LOW && rw) begin
        rdat_nxt = mlo_r;
        rcnt_nxt = CNT_WORD;
      end else if (cmd_code_in == CMD_STATUS_WORD && rw) begin
        rdat_nxt = stat_r;
        rcnt_nxt = CNT_WORD;
      end else if (cmd_code_in == CMD_READ_VOUT && rw) begin
        rdat_nxt = vout_mant_in;
        rcnt_nxt = CNT_WORD;
      end else if (cmd_code_in == CMD_TEMP_OTHER && rw) begin
        rdat_nxt = {TEMP_EXP, thermistor_other_in};
        rcnt_nxt = CNT_WORD;
      end else if (cmd_code_in == CMD_POWER_OUT && rw) begin
        rdat_nxt = {POWER_EXP, pout_mant_in};
        rcnt_nxt = CNT_WORD;
      end else if (cmd_code_in == CMD_POWER_IN && rw) begin
        rdat_nxt = {POWER_EXP, pin_mant_in};
        rcnt_nxt = CNT_WORD;
      end else if (cmd_code_in == CMD_PROTO_REV && rb) begin
        rdat_nxt = {8'h00, PROTO_REV_CODE};
        rcnt_nxt = CNT_BYTE;
      end else if (cmd_code_in == CMD_MODEL && cmd_kind_in == KIND_BLOCK) begin
        rdat_nxt = {MODEL_ID, MODEL_LOW};
        rcnt_nxt = CNT_WORD;
      end else if (cmd_code_in == CMD_SI_REV && cmd_kind_in == KIND_BLOCK) begin
        rdat_nxt = {SI_REV, MODEL_LOW};
        rcnt_nxt = CNT_WORD;
      end else if (cmd_code_in == CMD_PCALL_WRITE && cmd_kind_in == KIND_PCALL) begin
        rwr_nxt = 1'b1;
        raddr_nxt = cmd_data_in[7:0];
        rwd_nxt = cmd_data_in[15:8];
        rdat_nxt = cmd_data_in;
        rcnt_nxt = CNT_WORD;
      end else if (cmd_code_in == CMD_PCALL_READ && cmd_kind_in == KIND_PCALL) begin
        rv_nxt = 1'b0;
        rrd_nxt = 1'b1;
        raddr_nxt = cmd_data_in[7:0];
        rcnt_nxt = CNT_WORD;
        state_nxt = PMD_REG_RD;
      end else if (cmd_code_in == CMD_OVERCLOCK && ww) begin
        oc_nxt = cmd_data_in;
      end else if (cmd_code_in == CMD_SET_INDEX && wb) begin
        index_nxt = cmd_data_in[7:0];
      end else if (cmd_code_in == CMD_FETCH_BYTE && rb) begin
        rv_nxt = 1'b0;
        rrd_nxt = 1'b1;
        raddr_nxt = index_r;
        rcnt_nxt = CNT_BYTE;
        state_nxt = PMD_REG_RD;
      end else if (cmd_code_in == CMD_DIRECT_WRITE && ww) begin
        rwr_nxt = 1'b1;
        raddr_nxt = cmd_data_in[7:0];
        rwd_nxt = cmd_data_in[15:8];
      end else if (cmd_code_in == CMD_SEC_ADDR && wb) begin
        sec_nxt = cmd_data_in[7:0];
      end else if (cmd_code_in == CMD_SEC_ADDR && rb) begin
        rdat_nxt = {8'h00, sec_r};
        rcnt_nxt = CNT_BYTE;
      end else if (cmd_code_in == CMD_EFFICIENCY && rw) begin
        rdat_nxt = {EFF_EXP, eff_mant_in};
        rcnt_nxt = CNT_WORD;
      end else if (cmd_code_in == CMD_MASK_WORD && ww) begin
        mword_nxt = cmd_data_in;
      end else if (cmd_code_in == CMD_MASK_WORD && rw) begin
        rdat_nxt = mword_r;
        rcnt_nxt = CNT_WORD;
      end else if (cmd_code_in == CMD_MASK_TEMP && wb) begin
        mtemp_nxt = cmd_data_in[7:0];
      end else if (cmd_code_in == CMD_MASK_TEMP && rb) begin
        rdat_nxt = {8'h00, mtemp_r};
        rcnt_nxt = CNT_BYTE;
      end else if (cmd_code_in == CMD_MASK_COMM && wb) begin
        mcomm_nxt = cmd_data_in[7:0];
      end else if (cmd_code_in == CMD_MASK_COMM && rb) begin
        rdat_nxt = {8'h00, mcomm_r};
        rcnt_nxt = CNT_BYTE;
      end else if (cmd_code_in == CMD_MASK_MFR && wb) begin
        mmfr_nxt = cmd_data_in[7:0];
      end else if (cmd_code_in == CMD_MASK_MFR && rb) begin
        rdat_nxt = {8'h00, mmfr_r};
        rcnt_nxt = CNT_BYTE;
      end else begin
        rerr_nxt = 1'b1; // Unknown code or wrong protocol
      end
    end
    // Rising edge of the zero level sets the flag; set beats clear
    if (vout_zero_in && !zprev_r) begin
      zero_nxt = 1'b1;
    end
  end

  // Registers, frozen while the clock enable is low
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      state_r <= PMD_IDLE;
      index_r <= INDEX_RST;
      oc_r <= OVERCLOCK_RST;
      sec_r <= SEC_ADDR_RST;
      vmode_r <= VOUT_MODE_RST;
      mhi_r <= MARGIN_RST;
      mlo_r <= MARGIN_RST;
      mword_r <= MASK_WORD_RST;
      mtemp_r <= MASK_BYTE_RST;
      mcomm_r <= MASK_BYTE_RST;
      mmfr_r <= MASK_BYTE_RST;
      zero_r <= 1'b0;
      zprev_r <= 1'b0;
      rv_r <= 1'b0;
      rerr_r <= 1'b0;
      clr_r <= 1'b0;
      rdat_r <= 16'h0000;
      rcnt_r <= CNT_NONE;
      rwr_r <= 1'b0;
      rrd_r <= 1'b0;
      raddr_r <= 8'h00;
      rwd_r <= 8'h00;
      stat_r <= 16'h0000;
    end else if (ce_in) begin
      state_r <= state_nxt;
      index_r <= index_nxt;
      oc_r <= oc_nxt;
      sec_r <= sec_nxt;
      vmode_r <= vmode_nxt;
      mhi_r <= mhi_nxt;
      mlo_r <= mlo_nxt;
      mword_r <= mword_nxt;
      mtemp_r <= mtemp_nxt;
      mcomm_r <= mcomm_nxt;
      mmfr_r <= mmfr_nxt;
      zero_r <= zero_nxt;
      zprev_r <= zprev_nxt;
      rv_r <= rv_nxt;
      rerr_r <= rerr_nxt;
      clr_r <= clr_nxt;
      rdat_r <= rdat_nxt;
      rcnt_r <= rcnt_nxt;
      rwr_r <= rwr_nxt;
      rrd_r <= rrd_nxt;
      raddr_r <= raddr_nxt;
      rwd_r <= rwd_nxt;
      stat_r <= stat_nxt;
    end
  end

  // Outputs straight from flip-flops, except cmd_ready_out, which is gated by rst_in and ce_in
  assign cmd_ready_out = state_r == PMD_IDLE && !rst_in ? ce_in : 1'b0;
  assign rsp_valid_out = rv_r;
  assign rsp_data_out = rdat_r;
  assign rsp_count_out = rcnt_r;
  assign rsp_error_out = rerr_r;
  assign reg_wr_out = rwr_r;
  assign reg_rd_out = rrd_r;
  assign reg_addr_out = raddr_r;
  assign reg_wdata_out = rwd_r;
  assign status_word_out = stat_r;
  assign mask_temp_out = mtemp_r;
  assign comm_status_suppress_out = mcomm_r;
  assign mask_mfr_out = mmfr_r;
  assign clear_faults_out = clr_r;
  assign overclock_out = oc_r;
  assign sec_addr_out = sec_r[6:0];
  assign sec_en_out = sec_r[7];
  assign vout_exp_out = vmode_r[4:0];
  assign margin_high_out = mhi_r;
  assign margin_low_out = mlo_r;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (rst_in);

  logic take_ce;
  assign take_ce = taken && ce_in;

  temp_read_a: assert property (take_ce && cmd_code_in == CMD_TEMP_OTHER && rw
    |=> rsp_valid_out && rsp_data_out == {TEMP_EXP, $past(thermistor_other_in)})
    else $error("other loop temperature answer wrong");
  pout_read_a: assert property (take_ce && cmd_code_in == CMD_POWER_OUT && rw
    |=> rsp_data_out == {POWER_EXP, $past(pout_mant_in)} && rsp_count_out == CNT_WORD)
    else $error("output power answer wrong");
  proto_rev_a: assert property (take_ce && cmd_code_in == CMD_PROTO_REV && rb
    |=> rsp_data_out[7:0] == 8'h12 && !rsp_error_out)
    else $error("protocol revision answer wrong");
  fetch_read_a: assert property (take_ce && cmd_code_in == CMD_FETCH_BYTE && rb
    |=> reg_rd_out && reg_addr_out == $past(index_r) && !rsp_valid_out
    ##1 (!$past(ce_in) || rsp_valid_out && rsp_count_out == CNT_BYTE))
    else $error("indexed byte read sequence wrong");
  direct_write_a: assert property (take_ce && cmd_code_in == CMD_DIRECT_WRITE && ww
    |=> reg_wr_out && reg_addr_out == $past(cmd_data_in[7:0]) && reg_wdata_out == $past(cmd_data_in[15:8]))
    else $error("direct register write wrong");
  sec_addr_a: assert property (take_ce && cmd_code_in == CMD_SEC_ADDR && wb
    |=> sec_addr_out == $past(cmd_data_in[6:0]) && sec_en_out == $past(cmd_data_in[7]))
    else $error("secondary address setup wrong");
  zero_sticky_a: assert property (zero_r && !(take_ce && cmd_code_in == CMD_CLEAR_FAULTS
    && cmd_kind_in == KIND_SEND) |=> zero_r)
    else $error("zero flag dropped without clear");
  zero_set_a: assert property (ce_in && vout_zero_in && !zprev_r |=> zero_r)
    else $error("zero flag not set");
  index_hold_a: assert property ($changed(index_r) |-> $past(take_ce && cmd_code_in == CMD_SET_INDEX && wb))
    else $error("read index changed without index write");
  mode_range_a: assert property (vout_exp_out <= VOUT_EXP_MAX || vout_exp_out >= VOUT_EXP_MIN)
    else $error("voltage exponent out of range");
  mask_apply_a: assert property (ce_in |=> status_word_out[15:12] == $past(status_word_in[15:12] & ~mword_r[15:12]))
    else $error("status mask not applied");

  fetch_cov_c: cover property (take_ce && cmd_code_in == CMD_FETCH_BYTE && rb ##2 rsp_valid_out);
  clear_cov_c: cover property (zero_r ##1 take_ce && cmd_code_in == CMD_CLEAR_FAULTS ##1 !zero_r);
  model_cov_c: cover property (take_ce && cmd_code_in == CMD_MODEL && cmd_kind_in == KIND_BLOCK);
  error_cov_c: cover property (rsp_valid_out && rsp_error_out);

endmodule : pmd_decoder

//--- testbench/pmd_regfile_model.sv
// Model of the internal register file behind the decoder.
// Assumes reads are sampled by the decoder one edge after reg_rd_in.
module pmd_regfile_model (
  // Clock
  input wire logic mclk_in,
  // Access port
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  output logic [7:0] reg_rdata_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [256];

  // Store written bytes
  always @(posedge mclk_in) begin
    if (reg_wr_in) begin
      mem[reg_addr_in] <= reg_wdata_in;
    end
  end

  // Outside a read the data lines show the inverse, never a stale value
  assign reg_rdata_out = reg_rd_in ? mem[reg_addr_in] : ~mem[reg_addr_in];
endmodule : pmd_regfile_model

//--- testbench/pmd_decoder_test.sv
// Self-checking bench for the manufacturer command decoder.
// Assumes the register file model beside the decoder and a 100 MHz clock.
module pmd_decoder_test import pmd_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 0, rst = 1, ce = 1, valid = 0, rd, wr, zero = 0;
  logic [7:0] code = 0, addr, wdata, rdata;
  logic [2:0] kind = 0;
  logic [15:0] data = 0, st_in = 16'h00F0;
  logic [15:0] rsp_data, st_out, ovc, mhi, mlo;
  logic rdy, rsp_valid, rsp_err, sec_en, clr;
  logic [1:0] rsp_cnt;
  logic [7:0] mtemp, mcomm, mmfr;
  logic [6:0] sec_addr;
  logic [4:0] vexp;
  int fails = 0, cmp_count = 0;

  always #5 mclk = ~mclk;

  pmd_decoder DUT (.mclk_in(mclk), .rst_in(rst), .ce_in(ce), .cmd_valid_in(valid), .cmd_code_in(code),
    .cmd_kind_in(kind), .cmd_data_in(data), .cmd_ready_out(rdy), .rsp_valid_out(rsp_valid),
    .rsp_data_out(rsp_data), .rsp_count_out(rsp_cnt), .rsp_error_out(rsp_err), .reg_wr_out(wr),
    .reg_rd_out(rd), .reg_addr_out(addr), .reg_wdata_out(wdata), .reg_rdata_in(rdata),
    .thermistor_other_in(11'h123), .pout_mant_in(11'h345), .pin_mant_in(11'h567), .eff_mant_in(11'h05F),
    .vout_mant_in(16'h1A2B), .vout_zero_in(zero), .status_word_in(st_in), .status_word_out(st_out),
    .mask_temp_out(mtemp), .comm_status_suppress_out(mcomm), .mask_mfr_out(mmfr), .clear_faults_out(clr),
    .overclock_out(ovc), .sec_addr_out(sec_addr), .sec_en_out(sec_en), .vout_exp_out(vexp),
    .margin_high_out(mhi), .margin_low_out(mlo));

  pmd_regfile_model REGS (.mclk_in(mclk), .reg_wr_in(wr), .reg_rd_in(rd), .reg_addr_in(addr),
    .reg_wdata_in(wdata), .reg_rdata_out(rdata));

  // ****
  // Tasks
  // ****
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] s);
    cmp_count++;
    if (s !== e) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask : chk

  // One transaction: present, wait until taken, then check the answer
  task automatic cmd(input logic [7:0] c, input logic [2:0] k, input logic [15:0] d,
                     input logic [1:0] cn, input logic er, input bit cd, input logic [15:0] ed);
    int n;
    code = c;
    kind = k;
    data = d;
    valid = 1;
    n = 0;
    while (rdy !== 1'b1 && n < 8) begin
      @(posedge mclk); #1;
      n++;
    end
    @(posedge mclk); #1;
    valid = 0;
    n = 0;
    while (rsp_valid !== 1'b1 && n < 4) begin
      @(posedge mclk); #1;
      n++;
    end
    chk("rsp_valid", 16'h0001, {15'h0, rsp_valid});
    chk("rsp_error", {15'h0, er}, {15'h0, rsp_err});
    chk("rsp_count", {14'h0, cn}, {14'h0, rsp_cnt});
    chk("clear_faults", {15'h0, c == CMD_CLEAR_FAULTS && k == KIND_SEND}, {15'h0, clr});
    if (cd) begin
      chk("rsp_data", ed, rsp_data);
    end
    @(posedge mclk); #1;
  endtask : cmd

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : wrap_up

  // Watchdog far beyond the hundred or so cycles the tests need
  initial begin
    #50us;
    fails++;
    wrap_up();
  end

  // ****
  // Tests
  // ****
  initial begin
    repeat (6) @(posedge mclk);
    #1;
    rst = 0;
    chk("vout_exp", 16'h0017, {11'h0, vexp});
    chk("sec_en", 16'h0000, {15'h0, sec_en});
    ce = 0;
    #1;
    chk("ready_ce_low", 16'h0000, {15'h0, rdy});
    @(posedge mclk); #1;
    ce = 1;
    $display("test reset done");
    cmd(CMD_TEMP_OTHER, KIND_RWORD, 0, CNT_WORD, 0, 1, {TEMP_EXP, 11'h123});
    cmd(CMD_POWER_OUT, KIND_RWORD, 0, CNT_WORD, 0, 1, {POWER_EXP, 11'h345});
    cmd(CMD_POWER_IN, KIND_RWORD, 0, CNT_WORD, 0, 1, {POWER_EXP, 11'h567});
    cmd(CMD_EFFICIENCY, KIND_RWORD, 0, CNT_WORD, 0, 1, {EFF_EXP, 11'h05F});
    cmd(CMD_PROTO_REV, KIND_RBYTE, 0, CNT_BYTE, 0, 1, 16'h0012);
    cmd(CMD_MODEL, KIND_BLOCK, 0, CNT_WORD, 0, 1, 16'h5A3C);
    cmd(CMD_SI_REV, KIND_BLOCK, 0, CNT_WORD, 0, 1, 16'h023C);
    cmd(CMD_TEMP_OTHER, KIND_WBYTE, 0, CNT_NONE, 1, 0, 0);
    $display("test telemetry done");
    cmd(CMD_DIRECT_WRITE, KIND_WWORD, 16'hA512, CNT_NONE, 0, 0, 0);
    cmd(CMD_SET_INDEX, KIND_WBYTE, 16'h0012, CNT_NONE, 0, 0, 0);
    cmd(CMD_FETCH_BYTE, KIND_RBYTE, 0, CNT_BYTE, 0, 1, 16'h00A5);
    cmd(CMD_PCALL_WRITE, KIND_PCALL, 16'h3C12, CNT_WORD, 0, 1, 16'h3C12);
    cmd(CMD_FETCH_BYTE, KIND_RBYTE, 0, CNT_BYTE, 0, 1, 16'h003C);
    cmd(CMD_PCALL_WRITE, KIND_PCALL, 16'h6607, CNT_WORD, 0, 1, 16'h6607);
    cmd(CMD_PCALL_READ, KIND_PCALL, 16'h0007, CNT_WORD, 0, 1, 16'h0066);
    $display("test indirect done");
    cmd(CMD_OVERCLOCK, KIND_WWORD, 16'hBEEF, CNT_NONE, 0, 0, 0);
    chk("overclock", 16'hBEEF, ovc);
    cmd(CMD_SEC_ADDR, KIND_WBYTE, 16'h0085, CNT_NONE, 0, 0, 0);
    chk("sec_addr", 16'h0005, {9'h0, sec_addr});
    chk("sec_en", 16'h0001, {15'h0, sec_en});
    cmd(CMD_SEC_ADDR, KIND_RBYTE, 0, CNT_BYTE, 0, 1, 16'h0085);
    chk("status_out", 16'h00F0, st_out);
    cmd(CMD_MASK_WORD, KIND_WWORD, 16'h0030, CNT_NONE, 0, 0, 0);
    cmd(CMD_MASK_WORD, KIND_RWORD, 0, CNT_WORD, 0, 1, 16'h0030);
    cmd(CMD_STATUS_WORD, KIND_RWORD, 0, CNT_WORD, 0, 1, 16'h00C0);
    chk("status_out", 16'h00C0, st_out);
    cmd(CMD_MASK_TEMP, KIND_WBYTE, 16'h0081, CNT_NONE, 0, 0, 0);
    cmd(CMD_MASK_COMM, KIND_WBYTE, 16'h0042, CNT_NONE, 0, 0, 0);
    cmd(CMD_MASK_MFR, KIND_WBYTE, 16'h0024, CNT_NONE, 0, 0, 0);
    chk("mask_bytes", 16'h8142, {mtemp, mcomm});
    cmd(CMD_MASK_MFR, KIND_RBYTE, 0, CNT_BYTE, 0, 1, 16'h0024);
    chk("mask_mfr", 16'h0024, {8'h0, mmfr});
    cmd(CMD_MASK_TEMP, KIND_RBYTE, 0, CNT_BYTE, 0, 1, 16'h0081);
    cmd(CMD_MASK_COMM, KIND_RBYTE, 0, CNT_BYTE, 0, 1, 16'h0042);
    $display("test config done");
    zero = 1;
    repeat (3) @(posedge mclk);
    #1;
    chk("zero_flag_set", 16'h08C0, st_out);
    zero = 0;
    repeat (3) @(posedge mclk);
    #1;
    chk("zero_flag_held", 16'h08C0, st_out);
    cmd(CMD_STATUS_WORD, KIND_RWORD, 0, CNT_WORD, 0, 1, 16'h08C0);
    cmd(CMD_CLEAR_FAULTS, KIND_SEND, 0, CNT_NONE, 0, 0, 0);
    repeat (2) @(posedge mclk);
    #1;
    chk("zero_flag_clr", 16'h00C0, st_out);
    $display("test zero flag done");
    cmd(CMD_VOUT_MODE, KIND_WBYTE, 16'h001F, CNT_NONE, 0, 0, 0);
    chk("vout_exp", 16'h001F, {11'h0, vexp});
    cmd(CMD_VOUT_MODE, KIND_WBYTE, 16'h0005, CNT_NONE, 1, 0, 0);
    chk("vout_exp_kept", 16'h001F, {11'h0, vexp});
    cmd(CMD_READ_VOUT, KIND_RWORD, 0, CNT_WORD, 0, 1, 16'h1A2B);
    cmd(CMD_MARGIN_HIGH, KIND_WWORD, 16'h9234, CNT_NONE, 0, 0, 0);
    cmd(CMD_MARGIN_HIGH, KIND_RWORD, 0, CNT_WORD, 0, 1, 16'h9234);
    chk("margin_high", 16'h9234, mhi);
    cmd(CMD_MARGIN_LOW, KIND_WWORD, 16'h8765, CNT_NONE, 0, 0, 0);
    cmd(CMD_MARGIN_LOW, KIND_RWORD, 0, CNT_WORD, 0, 1, 16'h8765);
    chk("margin_low", 16'h8765, mlo);
    cmd(CMD_VOUT_MODE, KIND_RBYTE, 0, CNT_BYTE, 0, 1, 16'h001F);
    $display("test voltage done");
    wrap_up();
  end
endmodule : pmd_decoder_test
